// [rtl/pfbc_top.sv]
// PWM generator fault override and leading-edge blanking control
// Operation
// - Five-bit source code picks faults 1-8, comparators 1-5 or fault 32.
// - Polarity bit set makes the selected fault active-low, else active-high.
// - Mode 11 disables the fault input; reserved mode 10 also does nothing.
// - Mode 01: active fault forces both outputs to override values per cycle.
// - Mode 00: active fault forces both outputs to override values, latched.
// - With write protect set, fault control writes need the unlock sequence.
// - High-side rising edge starts blanking when its trigger bit is set.
// - High-side falling edge starts blanking when its trigger bit is set.
// - Low-side rising edge starts blanking when its trigger bit is set.
// - Blanking register: bits 15-10 and 5-0 read-write, zero reset, rest zero.
// - Low-side falling edge starts blanking when its trigger bit is set.
// - Blank enables apply edge blanking to fault and current-limit inputs.
// - Six state enables suppress fault and current-limit while conditions hold.
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
module pfbc_top
	import pfbc_pkg::*;
#(
	parameter int LEB_W = PFBC_LEB_W
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [PFBC_ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	// AXI4-Lite write data
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// AXI4-Lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// AXI4-Lite read address
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [PFBC_ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	// AXI4-Lite read data
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// Fault sources
	input wire logic [7:0] fault_in,
	input wire logic [4:0] cmp_in,
	input wire logic fault32_in,
	input wire logic climit_in,
	// Generator side
	input wire logic high_side_in,
	input wire logic low_side_in,
	input wire logic period_start,
	input wire logic [1:0] fault_override_values,
	input wire logic [LEB_W-1:0] blank_delay,
	input wire logic blank_signal,
	input wire logic write_protect_config,
	// Pin side
	output logic high_side_output,
	output logic low_side_output,
	output logic fault_active,
	output logic climit_out,
	output logic irq
);
	// Bus state
	logic aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got;
	logic [PFBC_ADDR_W-1:0] aw_addr_ff, nxt_aw_addr;
	logic [31:0] w_data_ff, nxt_w_data;
	logic [3:0] w_strb_ff, nxt_w_strb;
	logic awready_ff, nxt_awready, wready_ff, nxt_wready;
	logic bvalid_ff, nxt_bvalid, arready_ff, nxt_arready;
	logic rvalid_ff, nxt_rvalid;
	logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
	logic [31:0] rdata_ff, nxt_rdata;
	// Register state
	logic [15:0] fcl_ff, nxt_fcl, blank_ff, nxt_blank;
	logic [PFBC_IRQ_W-1:0] stat_ff, nxt_stat, ien_ff, nxt_ien;
	logic key_seen_ff, nxt_key_seen, unlocked_ff, nxt_unlocked, latch_clr;
	// Fault path state
	pfbc_ovr_t ovr_ff, nxt_ovr;
	logic h_prev_ff, l_prev_ff, h_out_ff, nxt_h_out, l_out_ff, nxt_l_out;
	logic fact_ff, nxt_fact, cl_out_ff, nxt_cl_out, irq_ff, nxt_irq;
	// Combinational helpers
	logic aw_take, w_take, ar_take, wr_fire, lock_refused;
	logic leb_trigger, leb_busy, state_blank, fault_hit;
	logic [PFBC_IRQ_W-1:0] irq_events;

	// Byte-lane merge of a 16-bit register, masked to writable bits
	function automatic logic [15:0] merge16(input logic [15:0] old,
			input logic [31:0] data, input logic [3:0] strb,
			input logic [15:0] mask);
		logic [15:0] res;
		res = old;
		if (strb[0]) begin
			res[7:0] = data[7:0];
		end
		if (strb[1]) begin
			res[15:8] = data[15:8];
		end
		return res & mask;
	endfunction

	// Selected fault source, reserved codes read low
	function automatic logic src_mux(input logic [4:0] code,
			input logic [7:0] flt, input logic [4:0] cmp,
			input logic f32);
		logic [4:0] idx;
		idx = code - PFBC_SRC_CMP_FIRST;
		if (code <= PFBC_SRC_FLT_LAST) begin
			return flt[code[2:0]];
		end else if (code <= PFBC_SRC_CMP_LAST) begin
			return cmp[idx[2:0]];
		end else if (code == PFBC_SRC_FLT32) begin
			return f32;
		end
		return 1'b0;
	endfunction

	// Read mux
	function automatic logic [31:0] read_mux(input logic [PFBC_ADDR_W-1:0] a,
			input logic [15:0] fcl, input logic [15:0] blk,
			input logic [PFBC_IRQ_W-1:0] st, input logic [PFBC_IRQ_W-1:0] en,
			input logic ovr, input logic leb);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (a)
			PFBC_OFS_FCL: r[15:0] = fcl;
			PFBC_OFS_BLANK: r[15:0] = blk;
			PFBC_OFS_STAT: begin
				r[PFBC_IRQ_W-1:0] = st;
				r[PFBC_STAT_OVR] = ovr;
				r[PFBC_STAT_LEB] = leb;
			end
			PFBC_OFS_IEN: r[PFBC_IRQ_W-1:0] = en;
			default: r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	function automatic logic mapped(input logic [PFBC_ADDR_W-1:0] a);
		return a[1:0] == 2'h0 && a <= PFBC_OFS_IEN;
	endfunction

	// AXI4-Lite handshakes and register writes
	always_comb begin
		aw_take = s_axi_awvalid & awready_ff;
		w_take = s_axi_wvalid & wready_ff;
		ar_take = s_axi_arvalid & arready_ff;
		wr_fire = aw_got_ff & w_got_ff & ~bvalid_ff;
		nxt_aw_got = wr_fire ? 1'b0 : (aw_got_ff | aw_take);
		nxt_w_got = wr_fire ? 1'b0 : (w_got_ff | w_take);
		nxt_aw_addr = aw_take ? s_axi_awaddr : aw_addr_ff;
		nxt_w_data = w_take ? s_axi_wdata : w_data_ff;
		nxt_w_strb = w_take ? s_axi_wstrb : w_strb_ff;
		nxt_bvalid = wr_fire | (bvalid_ff & ~s_axi_bready);
		nxt_awready = ~nxt_aw_got & ~nxt_bvalid;
		nxt_wready = ~nxt_w_got & ~nxt_bvalid;
		nxt_rvalid = ar_take | (rvalid_ff & ~s_axi_rready);
		nxt_arready = ~nxt_rvalid;
		nxt_rdata = rdata_ff;
		nxt_rresp = rresp_ff;
		if (ar_take) begin
			nxt_rdata = read_mux(s_axi_araddr, fcl_ff, blank_ff, stat_ff,
				ien_ff, ovr_ff != PFBC_OVR_IDLE, leb_busy);
			nxt_rresp = mapped(s_axi_araddr) ? PFBC_RESP_OKAY
				: PFBC_RESP_SLVERR;
		end
		nxt_bresp = bresp_ff;
		nxt_fcl = fcl_ff;
		nxt_blank = blank_ff;
		nxt_ien = ien_ff;
		nxt_key_seen = key_seen_ff;
		nxt_unlocked = unlocked_ff;
		lock_refused = 1'b0;
		latch_clr = 1'b0;
		if (wr_fire) begin
			nxt_bresp = mapped(aw_addr_ff) ? PFBC_RESP_OKAY
				: PFBC_RESP_SLVERR;
			case (aw_addr_ff)
				PFBC_OFS_FCL: begin
					if (write_protect_config && !unlocked_ff) begin
						lock_refused = 1'b1;
						nxt_bresp = PFBC_RESP_SLVERR;
					end else begin
						nxt_fcl = merge16(fcl_ff, w_data_ff, w_strb_ff,
							PFBC_FCL_MASK);
					end
					nxt_unlocked = 1'b0;
				end
				PFBC_OFS_BLANK: begin
					nxt_blank = merge16(blank_ff, w_data_ff, w_strb_ff,
						PFBC_BLANK_MASK);
				end
				PFBC_OFS_UNLOCK: begin
					// Two keys in a row arm one protected write
					nxt_key_seen = (w_data_ff[15:0] == PFBC_KEY1);
					if (key_seen_ff && w_data_ff[15:0] == PFBC_KEY2) begin
						nxt_unlocked = 1'b1;
					end
				end
				PFBC_OFS_CTRL: latch_clr = w_data_ff[PFBC_CTRL_LCLR];
				PFBC_OFS_IEN: nxt_ien = w_data_ff[PFBC_IRQ_W-1:0];
				default: nxt_key_seen = key_seen_ff;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			aw_addr_ff <= '0;
			w_data_ff <= 32'h0000_0000;
			w_strb_ff <= 4'h0;
			awready_ff <= 1'b0;
			wready_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= PFBC_RESP_OKAY;
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= PFBC_RESP_OKAY;
			fcl_ff <= PFBC_FCL_RST;
			blank_ff <= PFBC_BLANK_RST;
			ien_ff <= '0;
			key_seen_ff <= 1'b0;
			unlocked_ff <= 1'b0;
		end else begin
			aw_got_ff <= nxt_aw_got;
			w_got_ff <= nxt_w_got;
			aw_addr_ff <= nxt_aw_addr;
			w_data_ff <= nxt_w_data;
			w_strb_ff <= nxt_w_strb;
			awready_ff <= nxt_awready;
			wready_ff <= nxt_wready;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
			arready_ff <= nxt_arready;
			rvalid_ff <= nxt_rvalid;
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;
			fcl_ff <= nxt_fcl;
			blank_ff <= nxt_blank;
			ien_ff <= nxt_ien;
			key_seen_ff <= nxt_key_seen;
			unlocked_ff <= nxt_unlocked;
		end
	end

	// Edge triggers of the blanking counter
	assign leb_trigger =
		(blank_ff[PFBC_B_HRISE] & high_side_in & ~h_prev_ff) |
		(blank_ff[PFBC_B_HFALL] & ~high_side_in & h_prev_ff) |
		(blank_ff[PFBC_B_LRISE] & low_side_in & ~l_prev_ff) |
		(blank_ff[PFBC_B_LFALL] & ~low_side_in & l_prev_ff);

	pfbc_blank_counter #(
		.CNT_W(LEB_W)
	) u_leb (
		.aclk(aclk),
		.aresetn(aresetn),
		.trigger(leb_trigger),
		.delay(blank_delay),
		.busy(leb_busy)
	);

	// Fault qualification, override state and pin drive
	always_comb begin
		state_blank =
			(blank_ff[PFBC_B_SELHI] & blank_signal) |
			(blank_ff[PFBC_B_SELLO] & ~blank_signal) |
			(blank_ff[PFBC_B_HHI] & high_side_in) |
			(blank_ff[PFBC_B_HLO] & ~high_side_in) |
			(blank_ff[PFBC_B_LHI] & low_side_in) |
			(blank_ff[PFBC_B_LLO] & ~low_side_in);
		fault_hit = (src_mux(fcl_ff[PFBC_SRC_MSB:PFBC_SRC_LSB], fault_in,
			cmp_in, fault32_in) ^ fcl_ff[PFBC_POL_BIT]) &
			~(leb_busy & blank_ff[PFBC_B_FLTLEB]) &
			~state_blank;
		nxt_cl_out = climit_in & ~state_blank &
			~(leb_busy & blank_ff[PFBC_B_CLLEB]);
		nxt_ovr = ovr_ff;
		case (ovr_ff)
			PFBC_OVR_IDLE: begin
				if (fault_hit &&
						fcl_ff[PFBC_MOD_MSB:PFBC_MOD_LSB] == PFBC_MODE_CYCLE) begin
					nxt_ovr = PFBC_OVR_CYCLE;
				end else if (fault_hit &&
						fcl_ff[PFBC_MOD_MSB:PFBC_MOD_LSB] == PFBC_MODE_LATCH) begin
					nxt_ovr = PFBC_OVR_LATCH;
				end
			end
			PFBC_OVR_CYCLE: begin
				if (fcl_ff[PFBC_MOD_MSB:PFBC_MOD_LSB] != PFBC_MODE_CYCLE) begin
					nxt_ovr = PFBC_OVR_IDLE;
				end else if (period_start && !fault_hit) begin
					nxt_ovr = PFBC_OVR_IDLE;
				end
			end
			PFBC_OVR_LATCH: begin
				if (fcl_ff[PFBC_MOD_MSB] == PFBC_MODE_OFF[1]) begin
					nxt_ovr = PFBC_OVR_IDLE;
				end else if (latch_clr && !fault_hit) begin
					nxt_ovr = PFBC_OVR_IDLE;
				end
			end
			default: nxt_ovr = PFBC_OVR_IDLE;
		endcase
		nxt_fact = (nxt_ovr != PFBC_OVR_IDLE);
		nxt_h_out = nxt_fact ? fault_override_values[1] : high_side_in;
		nxt_l_out = nxt_fact ? fault_override_values[0] : low_side_in;
		irq_events = '0;
		irq_events[PFBC_IRQ_FAULT] = nxt_fact & (ovr_ff == PFBC_OVR_IDLE);
		irq_events[PFBC_IRQ_BLANK] = leb_trigger;
		irq_events[PFBC_IRQ_LOCK] = lock_refused;
		// Set wins over a clear in the same cycle
		nxt_stat = stat_ff;
		if (wr_fire && aw_addr_ff == PFBC_OFS_CLR) begin
			nxt_stat = stat_ff & ~w_data_ff[PFBC_IRQ_W-1:0];
		end
		nxt_stat = nxt_stat | irq_events;
		nxt_irq = |(nxt_stat & nxt_ien);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ovr_ff <= PFBC_OVR_IDLE;
			h_prev_ff <= 1'b0;
			l_prev_ff <= 1'b0;
			h_out_ff <= 1'b0;
			l_out_ff <= 1'b0;
			fact_ff <= 1'b0;
			cl_out_ff <= 1'b0;
			stat_ff <= '0;
			irq_ff <= 1'b0;
		end else begin
			ovr_ff <= nxt_ovr;
			h_prev_ff <= high_side_in;
			l_prev_ff <= low_side_in;
			h_out_ff <= nxt_h_out;
			l_out_ff <= nxt_l_out;
			fact_ff <= nxt_fact;
			cl_out_ff <= nxt_cl_out;
			stat_ff <= nxt_stat;
			irq_ff <= nxt_irq;
		end
	end

	assign s_axi_awready = awready_ff;
	assign s_axi_wready = wready_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	assign high_side_output = h_out_ff;
	assign low_side_output = l_out_ff;
	assign fault_active = fact_ff;
	assign climit_out = cl_out_ff;
	assign irq = irq_ff;
endmodule

// [rtl/pfbc_pkg.sv]
// Constants, register map and types of the PWM fault and blanking control
package pfbc_pkg;
	// Register byte offsets
	localparam logic [7:0] PFBC_OFS_FCL = 8'h00;
	localparam logic [7:0] PFBC_OFS_BLANK = 8'h04;
	localparam logic [7:0] PFBC_OFS_UNLOCK = 8'h08;
	localparam logic [7:0] PFBC_OFS_CTRL = 8'h0c;
	localparam logic [7:0] PFBC_OFS_STAT = 8'h10;
	localparam logic [7:0] PFBC_OFS_CLR = 8'h14;
	localparam logic [7:0] PFBC_OFS_IEN = 8'h18;
	// Reset values and writable masks
	localparam logic [15:0] PFBC_FCL_RST = 16'h00f8;
	localparam logic [15:0] PFBC_FCL_MASK = 16'h7fff;
	localparam logic [15:0] PFBC_BLANK_RST = 16'h0000;
	localparam logic [15:0] PFBC_BLANK_MASK = 16'hfc3f;
	// Fault control fields
	localparam int PFBC_SRC_MSB = 7;
	localparam int PFBC_SRC_LSB = 3;
	localparam int PFBC_POL_BIT = 2;
	localparam int PFBC_MOD_MSB = 1;
	localparam int PFBC_MOD_LSB = 0;
	// Blanking control fields
	localparam int PFBC_B_HRISE = 15;
	localparam int PFBC_B_HFALL = 14;
	localparam int PFBC_B_LRISE = 13;
	localparam int PFBC_B_LFALL = 12;
	localparam int PFBC_B_FLTLEB = 11;
	localparam int PFBC_B_CLLEB = 10;
	localparam int PFBC_B_SELHI = 5;
	localparam int PFBC_B_SELLO = 4;
	localparam int PFBC_B_HHI = 3;
	localparam int PFBC_B_HLO = 2;
	localparam int PFBC_B_LHI = 1;
	localparam int PFBC_B_LLO = 0;
	// Fault mode codes
	localparam logic [1:0] PFBC_MODE_LATCH = 2'h0;
	localparam logic [1:0] PFBC_MODE_CYCLE = 2'h1;
	localparam logic [1:0] PFBC_MODE_RSVD = 2'h2;
	localparam logic [1:0] PFBC_MODE_OFF = 2'h3;
	// Fault source codes
	localparam logic [4:0] PFBC_SRC_FLT_LAST = 5'h07;
	localparam logic [4:0] PFBC_SRC_CMP_FIRST = 5'h08;
	localparam logic [4:0] PFBC_SRC_CMP_LAST = 5'h0c;
	localparam logic [4:0] PFBC_SRC_FLT32 = 5'h1f;
	// Unlock keys and control bits
	localparam logic [15:0] PFBC_KEY1 = 16'h5a5a;
	localparam logic [15:0] PFBC_KEY2 = 16'ha5a5;
	localparam int PFBC_CTRL_LCLR = 0;
	// Interrupt status layout
	localparam int PFBC_IRQ_W = 3;
	localparam int PFBC_IRQ_FAULT = 0;
	localparam int PFBC_IRQ_BLANK = 1;
	localparam int PFBC_IRQ_LOCK = 2;
	localparam int PFBC_STAT_OVR = 8;
	localparam int PFBC_STAT_LEB = 9;
	// Bus responses
	localparam logic [1:0] PFBC_RESP_OKAY = 2'h0;
	localparam logic [1:0] PFBC_RESP_SLVERR = 2'h2;
	// Widths
	localparam int PFBC_LEB_W = 12;
	localparam int PFBC_ADDR_W = 8;

	typedef enum logic [1:0] {
		PFBC_OVR_IDLE = 2'b00,
		PFBC_OVR_CYCLE = 2'b01,
		PFBC_OVR_LATCH = 2'b10
	} pfbc_ovr_t;
endpackage

// [rtl/pfbc_blank_counter.sv]
// Leading-edge blanking down-counter
`timescale 1ns/100ps
module pfbc_blank_counter #(
	parameter int CNT_W = 12
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Control
	input wire logic trigger,
	input wire logic [CNT_W-1:0] delay,
	// Status
	output logic busy
);
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic busy_ff;
	logic nxt_busy;

	// Restart on every trigger, mask for delay cycles
	always_comb begin
		nxt_cnt = cnt_ff;
		if (trigger) begin
			nxt_cnt = delay;
		end else if (cnt_ff != '0) begin
			nxt_cnt = cnt_ff - 1'b1;
		end
		nxt_busy = (nxt_cnt != '0);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_ff <= '0;
			busy_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			busy_ff <= nxt_busy;
		end
	end

	assign busy = busy_ff;
endmodule

// [dv/pfbc_fault_model.sv]
// Model of the fault pins and comparator outputs
`timescale 1ns/100ps
module pfbc_fault_model (
	// Clock
	input wire logic aclk,
	// Command from the bench
	input wire logic [4:0] sel,
	input wire logic act,
	input wire logic pol,
	// Fault source lines
	output logic [7:0] fault_in,
	output logic [4:0] cmp_in,
	output logic fault32_in
);
	// Unselected lines run a changing pattern
	logic [13:0] noise_ff = 14'h2a5b;
	logic [13:0] lines;
	always_ff @(posedge aclk) begin
		noise_ff <= {noise_ff[12:0], noise_ff[13] ^ noise_ff[4]};
	end
	always_comb begin
		lines = noise_ff;
		if (sel <= 5'h0c) lines[sel[3:0]] = act ^ pol;
		else if (sel == 5'h1f) lines[13] = act ^ pol;
	end
	assign fault_in = lines[7:0];
	assign cmp_in = lines[12:8];
	assign fault32_in = lines[13];
endmodule

// [dv/pfbc_top_checker.sv]
// Port assertions for the fault and blanking control
`timescale 1ns/100ps
module pfbc_top_checker (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	// Generator and pins
	input wire logic climit_in,
	input wire logic high_side_in,
	input wire logic low_side_in,
	input wire logic [1:0] fault_override_values,
	input wire logic high_side_output,
	input wire logic low_side_output,
	input wire logic fault_active,
	input wire logic climit_out
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	property p_ovr;
		fault_active |->
			{high_side_output, low_side_output} == $past(fault_override_values);
	endproperty
	a_ovr: assert property (p_ovr) else $error("override value wrong");
	property p_pass_hi;
		!fault_active && $past(aresetn) |-> high_side_output == $past(high_side_in);
	endproperty
	a_pass_hi: assert property (p_pass_hi) else $error("high pin wrong");
	property p_pass_lo;
		!fault_active && $past(aresetn) |-> low_side_output == $past(low_side_in);
	endproperty
	a_pass_lo: assert property (p_pass_lo) else $error("low pin wrong");
	property p_climit;
		climit_out |-> $past(climit_in);
	endproperty
	a_climit: assert property (p_climit) else $error("climit not from input");
	property p_b_lat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|-> ##2 s_axi_bvalid;
	endproperty
	a_b_lat: assert property (p_b_lat) else $error("late write answer");
	property p_aw_block;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_aw_block: assert property (p_aw_block) else $error("write not refused");
	property p_r_lat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_r_lat: assert property (p_r_lat) else $error("late read answer");
	property p_ar_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("read not refused");
	c_ovr: cover property ($rose(fault_active));
	c_blank: cover property (climit_in && !climit_out);
	c_write: cover property (s_axi_bvalid);
endmodule
bind pfbc_top pfbc_top_checker pfbc_top_checker_inst (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .climit_in(climit_in),
	.high_side_in(high_side_in), .low_side_in(low_side_in),
	.fault_override_values(fault_override_values),
	.high_side_output(high_side_output), .low_side_output(low_side_output),
	.fault_active(fault_active), .climit_out(climit_out)
);

// [dv/pfbc_top_bench.sv]
// Self-checking bench for the fault and blanking control
`timescale 1ns/100ps
module pfbc_top_bench import pfbc_pkg::*;;
	logic aclk, aresetn, awv, wv, arv, awrdy, wrdy, arrdy, bv, rv;
	logic act, pol, cl, hi, lo, ps, bs, wp, ho, lo_o, fa, clo, irq, f32;
	logic [7:0] awa, ara, flt;
	logic [31:0] wd, rd;
	logic [1:0] bresp, rresp, ov;
	logic [4:0] cmp, sel;
	logic [11:0] dly;
	int num_errors = 0;
	int cmp_count = 0;
	pfbc_top pfbc_top_inst (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awvalid(awv), .s_axi_awready(awrdy), .s_axi_awaddr(awa),
		.s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
		.s_axi_wdata(wd), .s_axi_wstrb(4'h3), .s_axi_bvalid(bv),
		.s_axi_bready(1'b1), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
		.s_axi_arready(arrdy), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
		.s_axi_rvalid(rv), .s_axi_rready(1'b1), .s_axi_rdata(rd),
		.s_axi_rresp(rresp), .fault_in(flt), .cmp_in(cmp), .fault32_in(f32),
		.climit_in(cl), .high_side_in(hi), .low_side_in(lo),
		.period_start(ps), .fault_override_values(ov), .blank_delay(dly),
		.blank_signal(bs), .write_protect_config(wp),
		.high_side_output(ho), .low_side_output(lo_o), .fault_active(fa),
		.climit_out(clo), .irq(irq)
	);
	pfbc_fault_model pfbc_fault_model_inst (
		.aclk(aclk), .sel(sel), .act(act), .pol(pol),
		.fault_in(flt), .cmp_in(cmp), .fault32_in(f32)
	);
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	task automatic print_verdict;
		if (num_errors == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk1(input logic g, input logic e);
		chk(32'(g), 32'(e));
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic pulse_period;
		ps <= 1'b1;
		cyc(1);
		ps <= 1'b0;
		cyc(3);
	endtask
	// Bounded wait for one edge
	task automatic tick(inout int n);
		@(posedge aclk);
		n++;
		if (n > 200) begin
			num_errors++;
			print_verdict();
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] e);
		int n;
		n = 0;
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		do begin
			tick(n);
			if (awrdy) awv <= 1'b0;
			if (wrdy) wv <= 1'b0;
		end while (bv !== 1'b1);
		chk(32'(bresp), 32'(e));
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e, input logic [1:0] er);
		int n;
		n = 0;
		ara <= a;
		arv <= 1'b1;
		do begin
			tick(n);
			if (arrdy) arv <= 1'b0;
		end while (rv !== 1'b1);
		chk(rd & m, e);
		chk(32'(rresp), 32'(er));
	endtask
	initial begin
		logic [4:0] s;
		logic p;
		logic blk;
		logic lvl;
		logic e;
		int t;
		int b;
		void'($urandom(95));
		{awv, wv, arv, act, pol, cl, hi, lo, ps, bs, wp, aresetn} = '0;
		{awa, ara, wd, sel, ov} = '0;
		dly = 12'h008;
		cyc(5);
		aresetn <= 1'b1;
		cyc(3);
		rd_reg(PFBC_OFS_FCL, 32'hffff, 32'h00f8, PFBC_RESP_OKAY);
		rd_reg(PFBC_OFS_BLANK, 32'hffff, 32'h0, PFBC_RESP_OKAY);
		rd_reg(8'h40, 32'hffffffff, 32'h0, PFBC_RESP_SLVERR);
		wr_reg(PFBC_OFS_BLANK, 32'hffff, PFBC_RESP_OKAY);
		rd_reg(PFBC_OFS_BLANK, 32'hffffffff, 32'hfc3f, PFBC_RESP_OKAY);
		wr_reg(PFBC_OFS_BLANK, 32'h0, PFBC_RESP_OKAY);
		for (int c = 0; c < 15; c++) begin
			s = (c < 13) ? 5'(c) : ((c == 13) ? 5'h1f : 5'h1e);
			p = 1'($urandom());
			// Reserved source reads low, so active-low makes it a fault
			e = (c != 14) | p;
			ov <= 2'($urandom());
			wr_reg(PFBC_OFS_FCL, 32'({s, p, (c[0] ? 2'h2 : 2'h3)}),
				PFBC_RESP_OKAY);
			sel <= s;
			pol <= p;
			act <= 1'b1;
			cyc(3);
			chk1(fa, 1'b0);
			act <= 1'b0;
			wr_reg(PFBC_OFS_FCL, 32'({s, p, 2'h1}), PFBC_RESP_OKAY);
			act <= 1'b1;
			cyc(2);
			chk1(fa, e);
			chk(32'({ho, lo_o}), 32'(e ? ov : 2'h0));
			act <= 1'b0;
			cyc(3);
			chk1(fa, e);
			pulse_period();
			chk1(fa, e && c == 14);
		end
		wr_reg(PFBC_OFS_FCL, 32'h3, PFBC_RESP_OKAY);
		sel <= 5'h00;
		pol <= 1'b0;
		wr_reg(PFBC_OFS_FCL, 32'h0, PFBC_RESP_OKAY);
		wr_reg(PFBC_OFS_CLR, 32'h7, PFBC_RESP_OKAY);
		act <= 1'b1;
		cyc(2);
		chk1(fa, 1'b1);
		act <= 1'b0;
		pulse_period();
		chk1(fa, 1'b1);
		rd_reg(PFBC_OFS_STAT, 32'h101, 32'h101, PFBC_RESP_OKAY);
		chk1(irq, 1'b0);
		wr_reg(PFBC_OFS_IEN, 32'h1, PFBC_RESP_OKAY);
		cyc(2);
		chk1(irq, 1'b1);
		wr_reg(PFBC_OFS_CTRL, 32'h1, PFBC_RESP_OKAY);
		cyc(2);
		chk1(fa, 1'b0);
		wr_reg(PFBC_OFS_CLR, 32'h1, PFBC_RESP_OKAY);
		cyc(2);
		chk1(irq, 1'b0);
		wp <= 1'b1;
		wr_reg(PFBC_OFS_FCL, 32'h1, PFBC_RESP_SLVERR);
		rd_reg(PFBC_OFS_FCL, 32'hffff, 32'h0, PFBC_RESP_OKAY);
		rd_reg(PFBC_OFS_STAT, 32'h4, 32'h4, PFBC_RESP_OKAY);
		wr_reg(PFBC_OFS_UNLOCK, 32'(PFBC_KEY1), PFBC_RESP_OKAY);
		wr_reg(PFBC_OFS_UNLOCK, 32'(PFBC_KEY2), PFBC_RESP_OKAY);
		wr_reg(PFBC_OFS_FCL, 32'h1, PFBC_RESP_OKAY);
		wr_reg(PFBC_OFS_FCL, 32'h0, PFBC_RESP_SLVERR);
		rd_reg(PFBC_OFS_FCL, 32'hffff, 32'h1, PFBC_RESP_OKAY);
		wp <= 1'b0;
		cl <= 1'b1;
		// Matching edge blanks, the opposite edge does not
		for (int i = 0; i < 8; i++) begin
			b = i / 2;
			blk = (i % 2 == 0);
			lvl = b[0];
			t = blk ? 15 - b : 15 - (b ^ 1);
			if (b < 2) hi <= lvl;
			else lo <= lvl;
			wr_reg(PFBC_OFS_BLANK, 32'h0c00 | (32'h1 << t), PFBC_RESP_OKAY);
			cyc(12);
			if (b < 2) hi <= ~lvl;
			else lo <= ~lvl;
			cyc(2);
			act <= 1'b1;
			cyc(3);
			chk1(fa, !blk);
			chk1(clo, !blk);
			cyc(10);
			chk1(fa, 1'b1);
			act <= 1'b0;
			pulse_period();
		end
		for (int k = 0; k < 6; k++) begin
			lvl = k[0];
			wr_reg(PFBC_OFS_BLANK, 32'h1 << k, PFBC_RESP_OKAY);
			{bs, hi, lo} <= {3{lvl}};
			cyc(3);
			chk1(clo, 1'b0);
			{bs, hi, lo} <= {3{~lvl}};
			cyc(3);
			chk1(clo, 1'b1);
		end
		print_verdict();
	end
endmodule
